// File: common/lsc_map.svh
// How it works
// - Rotate after counting programmed reference pulses
// - Last error: nine bits over two registers
// - Under flag bit 7 below window
// - Over flag bit 6 above window
// - Sync runs only while enable set
// - Arm strobe arms one-shot on next event
// - Rising edge bit 5 clears sticky flags
// - Rising edge bit 4 clears last error
// - Mode field selects one-shot, continuous, monitor
// - Error within window counts as aligned
// - Pulse mode waits minimum LMFC counts
// - Sticky rotated and tripped flags
`ifndef LSC_MAP_SVH
`define LSC_MAP_SVH
`define LSC_ADDR_W        10
`define LSC_OFF_WINDOW    10'h034
`define LSC_OFF_MINCNT    10'h035
`define LSC_OFF_PULSECNT  10'h036
`define LSC_OFF_ERR_LO    10'h038
`define LSC_OFF_ERR_HI    10'h039
`define LSC_OFF_CTRL      10'h03a
`define LSC_OFF_IRQ_STAT  10'h03c
`define LSC_OFF_IRQ_MASK  10'h03d
`define LSC_BIT_ENABLE    7
`define LSC_BIT_ARM       6
`define LSC_BIT_CLRSTKY   5
`define LSC_BIT_CLRLAST   4
`define LSC_BIT_UNDER     7
`define LSC_BIT_OVER      6
`define LSC_RST_BYTE      8'h00
`define LSC_IRQ_ROTATE    0
`define LSC_IRQ_TRIP      1
`define LSC_IRQ_OUTWIN    2
`endif

// File: common/lsc_pkg.sv
package lsc_pkg;
  typedef enum logic [3:0] {
    MODE_OFF        = 4'b0000,
    MODE_ONESHOT    = 4'b0001,
    MODE_CONTINUOUS = 4'b0010,
    MODE_MONITOR    = 4'b1000,
    MODE_ONESHOT_MON = 4'b1001
  } lsc_mode_type;
  typedef struct packed {
    logic       alignLogicEnable;
    logic       oneShotArmStrobe;
    logic       stickyFlagClear;
    logic       lastErrorClear;
    logic [3:0] alignModeSelect;
  } lsc_ctrl_type;
  typedef struct packed {
    logic [8:0] lastPhaseError;
    logic       lastErrorUnderFlag;
    logic       lastErrorOverFlag;
  } lsc_err_type;
endpackage : lsc_pkg

// File: core/lsc_sync_ctrl.sv
// Added by the designer: the strobed register port.
`timescale 1ns/10ps
`include "lsc_map.svh"
module lsc_sync_ctrl (
  // Clock, reset, enable
  input  wire logic                   sys_clk,
  input  wire logic                   nrst,
  input  wire logic                   clkEn,
  // Register port
  input  wire logic [`LSC_ADDR_W-1:0] regAddr,
  input  wire logic [7:0]             regWdata,
  input  wire logic                   regWr,
  input  wire logic                   regRd,
  output logic      [7:0]             regRdata,
  // Sync inputs: sysref pin, LMFC boundary and measured phase error from the aligner
  input  wire logic                   sysrefPin,
  input  wire logic                   lmfcTick,
  input  wire logic [8:0]             phaseErr,
  // Aligner command and interrupt
  output logic                        rotateReq,
  output logic                        irq
);
  lsc_pkg::lsc_ctrl_type ctrl_q;
  lsc_pkg::lsc_err_type  err_q;
  logic [2:0] window_q;
  logic [7:0] minCount_q, pulseCount_q;
  logic [7:0] lmfcCnt_q, refCnt_q;
  logic       armed_q, oneShotDone_q;
  logic       rotated_q, tripped_q;
  logic [2:0] irqStat_q, irqMask_q;
  logic       sysMeta_q, sysSync_q, sysPrev_q;
  logic       clrStkyPrev_q, clrLastPrev_q;
  logic       sysEdge, active, outWin, under, over, doRotate, doMeasure;
  logic       clrStky, clrLast, pulseMode;
  logic signed [8:0] errS;
  logic signed [9:0] winS;

  // Write decode shared by every register
  function automatic logic hit(input logic [`LSC_ADDR_W-1:0] a, input logic [`LSC_ADDR_W-1:0] off);
    hit = (a == off);
  endfunction : hit

  // Pin synchroniser, edge taken from second stage only
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      sysMeta_q <= 1'b0;
      sysSync_q <= 1'b0;
      sysPrev_q <= 1'b0;
    end else if (clkEn) begin
      sysMeta_q <= sysrefPin;
      sysSync_q <= sysMeta_q;
      sysPrev_q <= sysSync_q;
    end
  end
  assign sysEdge = sysSync_q & ~sysPrev_q;

  // Control byte and plain setting registers
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_q       <= `LSC_RST_BYTE;
      window_q     <= 3'h0;
      minCount_q   <= `LSC_RST_BYTE;
      pulseCount_q <= `LSC_RST_BYTE;
      irqMask_q    <= 3'h0;
    end else if (clkEn && regWr) begin
      if (hit(regAddr, `LSC_OFF_CTRL))     ctrl_q       <= regWdata;
      if (hit(regAddr, `LSC_OFF_WINDOW))   window_q     <= regWdata[2:0];
      if (hit(regAddr, `LSC_OFF_MINCNT))   minCount_q   <= regWdata;
      if (hit(regAddr, `LSC_OFF_PULSECNT)) pulseCount_q <= regWdata;
      if (hit(regAddr, `LSC_OFF_IRQ_MASK)) irqMask_q    <= regWdata[2:0];
    end
  end

  // Edge detectors on the two clear bits; a held level does nothing more
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      clrStkyPrev_q <= 1'b0;
      clrLastPrev_q <= 1'b0;
    end else if (clkEn) begin
      clrStkyPrev_q <= ctrl_q.stickyFlagClear;
      clrLastPrev_q <= ctrl_q.lastErrorClear;
    end
  end
  assign clrStky = ctrl_q.stickyFlagClear & ~clrStkyPrev_q;
  assign clrLast = ctrl_q.lastErrorClear & ~clrLastPrev_q;

  // Window compare on the signed phase error
  assign errS  = $signed(phaseErr);
  assign winS  = $signed({7'h00, window_q});
  // Both sides signed; a bare concatenation is unsigned and would flag every error
  assign under = ($signed({errS[8], errS}) < -winS);
  assign over  = ($signed({errS[8], errS}) > winS);
  assign outWin = under | over;

  // Pulse mode is any mode that rotates on sysref
  assign pulseMode = (ctrl_q.alignModeSelect == lsc_pkg::MODE_ONESHOT) ||
                     (ctrl_q.alignModeSelect == lsc_pkg::MODE_CONTINUOUS) ||
                     (ctrl_q.alignModeSelect == lsc_pkg::MODE_ONESHOT_MON);
  assign active = ctrl_q.alignLogicEnable && (lmfcCnt_q >= minCount_q);

  // Rotate once enough pulses counted; one-shot needs arming, monitor never rotates
  always_comb begin
    doRotate = 1'b0;
    if (active && sysEdge && pulseMode && ((refCnt_q + 8'h01) >= pulseCount_q) && outWin) begin
      unique case (ctrl_q.alignModeSelect)
        lsc_pkg::MODE_CONTINUOUS:  doRotate = 1'b1;
        lsc_pkg::MODE_ONESHOT,
        lsc_pkg::MODE_ONESHOT_MON: doRotate = armed_q && !oneShotDone_q;
        default:                   doRotate = 1'b0;
      endcase
    end
  end
  assign doMeasure = active && sysEdge;
  assign rotateReq = doRotate;

  // LMFC counter for the start-up delay, and sysref pulse counter
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      lmfcCnt_q <= 8'h00;
      refCnt_q  <= 8'h00;
    end else if (clkEn) begin
      if (!ctrl_q.alignLogicEnable) begin
        lmfcCnt_q <= 8'h00;
        refCnt_q  <= 8'h00;
      end else begin
        if (lmfcTick && lmfcCnt_q != 8'hff) lmfcCnt_q <= lmfcCnt_q + 8'h01;
        if (doRotate || (active && sysEdge && (refCnt_q + 8'h01) >= pulseCount_q)) begin
          refCnt_q <= 8'h00;
        end else if (active && sysEdge) begin
          refCnt_q <= refCnt_q + 8'h01;
        end
      end
    end
  end

  // One-shot arming: write of the arm bit arms, first qualifying event consumes it
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      armed_q       <= 1'b0;
      oneShotDone_q <= 1'b0;
    end else if (clkEn) begin
      if (regWr && hit(regAddr, `LSC_OFF_CTRL) && regWdata[`LSC_BIT_ARM]) begin
        armed_q       <= 1'b1;
        oneShotDone_q <= 1'b0;
      end else if (armed_q && doMeasure && pulseMode) begin
        armed_q       <= 1'b0;
        oneShotDone_q <= 1'b1;
      end
    end
  end

  // Sticky flags; a new event wins over a clear edge in the same cycle
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rotated_q <= 1'b0;
      tripped_q <= 1'b0;
    end else if (clkEn) begin
      if (doRotate) rotated_q <= 1'b1;
      else if (clrStky) rotated_q <= 1'b0;
      if (armed_q && doMeasure) tripped_q <= 1'b1;
      else if (clrStky) tripped_q <= 1'b0;
    end
  end

  // Last error capture with under/over flags
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      err_q <= '0;
    end else if (clkEn) begin
      if (doMeasure) begin
        err_q.lastPhaseError     <= phaseErr;
        err_q.lastErrorUnderFlag <= under;
        err_q.lastErrorOverFlag  <= over;
      end else if (clrLast) begin
        err_q <= '0;
      end
    end
  end

  // Interrupt status: events set, a read of the status register clears; set wins
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      irqStat_q <= 3'h0;
    end else if (clkEn) begin
      irqStat_q <= ((regRd && hit(regAddr, `LSC_OFF_IRQ_STAT)) ? 3'h0 : irqStat_q) |
                   {doMeasure && outWin, armed_q && doMeasure, doRotate};
    end
  end
  assign irq = |(irqStat_q & irqMask_q);

  // Read data registered, valid the cycle after the strobe only
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      regRdata <= 8'h00;
    end else if (clkEn) begin
      regRdata <= 8'h00;
      if (regRd) begin
        unique case (regAddr)
          `LSC_OFF_WINDOW:   regRdata <= {5'h00, window_q};
          `LSC_OFF_MINCNT:   regRdata <= minCount_q;
          `LSC_OFF_PULSECNT: regRdata <= pulseCount_q;
          `LSC_OFF_ERR_LO:   regRdata <= err_q.lastPhaseError[7:0];
          `LSC_OFF_ERR_HI:   regRdata <= {err_q.lastErrorUnderFlag, err_q.lastErrorOverFlag,
                                          5'h00, err_q.lastPhaseError[8]};
          `LSC_OFF_CTRL:     regRdata <= {ctrl_q.alignLogicEnable, armed_q, ctrl_q.stickyFlagClear,
                                          ctrl_q.lastErrorClear, ctrl_q.alignModeSelect};
          `LSC_OFF_IRQ_STAT: regRdata <= {3'h0, rotated_q, tripped_q, irqStat_q};
          `LSC_OFF_IRQ_MASK: regRdata <= {5'h00, irqMask_q};
          default:           regRdata <= 8'h00;
        endcase
      end
    end
  end

  // Checks
  property p_rot_needs_enable;
    @(posedge sys_clk) disable iff (!nrst) rotateReq |-> ctrl_q.alignLogicEnable;
  endproperty
  a_rot_needs_enable: assert property (p_rot_needs_enable) else $error("rotate while disabled");
  property p_rot_needs_min;
    @(posedge sys_clk) disable iff (!nrst) rotateReq |-> lmfcCnt_q >= minCount_q;
  endproperty
  a_rot_needs_min: assert property (p_rot_needs_min) else $error("rotate before min LMFC count");
  property p_rot_sticky;
    @(posedge sys_clk) disable iff (!nrst) (rotateReq && clkEn) |=> rotated_q;
  endproperty
  a_rot_sticky: assert property (p_rot_sticky) else $error("rotated flag not set");
  property p_no_rot_monitor;
    @(posedge sys_clk) disable iff (!nrst) (ctrl_q.alignModeSelect == lsc_pkg::MODE_MONITOR) |-> !rotateReq;
  endproperty
  a_no_rot_monitor: assert property (p_no_rot_monitor) else $error("rotate in monitor mode");
  property p_in_window;
    @(posedge sys_clk) disable iff (!nrst) rotateReq |-> (under || over);
  endproperty
  a_in_window: assert property (p_in_window) else $error("rotate inside window");
  property p_err_capture;
    @(posedge sys_clk) disable iff (!nrst) (doMeasure && clkEn) |=> err_q.lastPhaseError == $past(phaseErr);
  endproperty
  a_err_capture: assert property (p_err_capture) else $error("last error not captured");
  property p_flags_excl;
    @(posedge sys_clk) disable iff (!nrst) !(err_q.lastErrorUnderFlag && err_q.lastErrorOverFlag);
  endproperty
  a_flags_excl: assert property (p_flags_excl) else $error("under and over both set");
  property p_clrlast;
    @(posedge sys_clk) disable iff (!nrst) (clrLast && !doMeasure && clkEn) |=> err_q == '0;
  endproperty
  a_clrlast: assert property (p_clrlast) else $error("last error not cleared");
  property p_clrstky;
    @(posedge sys_clk) disable iff (!nrst) (clrStky && !doRotate && clkEn) |=> !rotated_q;
  endproperty
  a_clrstky: assert property (p_clrstky) else $error("rotated flag not cleared");
  property p_reserved;
    @(posedge sys_clk) disable iff (!nrst) ($past(regRd) && $past(regAddr) == `LSC_OFF_ERR_HI && $past(clkEn))
      |-> regRdata[5:1] == 5'h00;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits nonzero");

  // Sticky flags: set by their events, cleared by a clear edge only
  property p_trip_sticky;
    @(posedge sys_clk) disable iff (!nrst) (armed_q && doMeasure && clkEn) |=> tripped_q;
  endproperty
  a_trip_sticky: assert property (p_trip_sticky) else $error("tripped flag not set");
  property p_clrstky_trip;
    @(posedge sys_clk) disable iff (!nrst) (clrStky && !(armed_q && doMeasure) && clkEn) |=> !tripped_q;
  endproperty
  a_clrstky_trip: assert property (p_clrstky_trip) else $error("tripped flag not cleared");
  property p_irq_rotate;
    @(posedge sys_clk) disable iff (!nrst) (doRotate && clkEn) |=> irqStat_q[`LSC_IRQ_ROTATE];
  endproperty
  a_irq_rotate: assert property (p_irq_rotate) else $error("rotate status bit not set");

  // Window flags checked against an independent signed compare
  property p_over_calc;
    @(posedge sys_clk) disable iff (!nrst) ($past(doMeasure) && $past(clkEn) &&
      ($signed($past(phaseErr)) > $signed({6'h00, $past(window_q)}))) |-> err_q.lastErrorOverFlag;
  endproperty
  a_over_calc: assert property (p_over_calc) else $error("over flag missing");
  property p_under_calc;
    @(posedge sys_clk) disable iff (!nrst) ($past(doMeasure) && $past(clkEn) &&
      ($signed($past(phaseErr)) < -$signed({6'h00, $past(window_q)}))) |-> err_q.lastErrorUnderFlag;
  endproperty
  a_under_calc: assert property (p_under_calc) else $error("under flag missing");
  property p_under_cap;
    @(posedge sys_clk) disable iff (!nrst) (doMeasure && clkEn) |=> err_q.lastErrorUnderFlag == $past(under);
  endproperty
  a_under_cap: assert property (p_under_cap) else $error("under flag not captured");
  property p_over_cap;
    @(posedge sys_clk) disable iff (!nrst) (doMeasure && clkEn) |=> err_q.lastErrorOverFlag == $past(over);
  endproperty
  a_over_cap: assert property (p_over_cap) else $error("over flag not captured");
  property p_err_hold;
    @(posedge sys_clk) disable iff (!nrst) (clkEn && !doMeasure && !clrLast) |=> $stable(err_q);
  endproperty
  a_err_hold: assert property (p_err_hold) else $error("last error changed without event");

  // Rotate only from a counted, qualifying sysref edge in a pulse mode
  property p_rot_edge;
    @(posedge sys_clk) disable iff (!nrst) rotateReq |-> sysEdge;
  endproperty
  a_rot_edge: assert property (p_rot_edge) else $error("rotate without sysref edge");
  property p_rot_count;
    @(posedge sys_clk) disable iff (!nrst) rotateReq |-> ((refCnt_q + 8'h01) >= pulseCount_q);
  endproperty
  a_rot_count: assert property (p_rot_count) else $error("rotate before pulse count");
  property p_rot_pulse_mode;
    @(posedge sys_clk) disable iff (!nrst) rotateReq |-> pulseMode;
  endproperty
  a_rot_pulse_mode: assert property (p_rot_pulse_mode) else $error("rotate outside pulse mode");
  property p_cont_rotates;
    @(posedge sys_clk) disable iff (!nrst) (doMeasure && outWin && ((refCnt_q + 8'h01) >= pulseCount_q) &&
      (ctrl_q.alignModeSelect == lsc_pkg::MODE_CONTINUOUS)) |-> rotateReq;
  endproperty
  a_cont_rotates: assert property (p_cont_rotates) else $error("continuous mode missed rotate");
  property p_oneshot_armed;
    @(posedge sys_clk) disable iff (!nrst) (rotateReq && (ctrl_q.alignModeSelect == lsc_pkg::MODE_ONESHOT))
      |-> armed_q;
  endproperty
  a_oneshot_armed: assert property (p_oneshot_armed) else $error("one-shot rotate while unarmed");

  // Arming: a write sets it, the first qualifying event consumes it
  property p_arm_write;
    @(posedge sys_clk) disable iff (!nrst) (clkEn && regWr && (regAddr == `LSC_OFF_CTRL) &&
      regWdata[`LSC_BIT_ARM]) |=> armed_q;
  endproperty
  a_arm_write: assert property (p_arm_write) else $error("arm write not taken");
  property p_arm_consumed;
    @(posedge sys_clk) disable iff (!nrst) (clkEn && armed_q && doMeasure && pulseMode && !regWr) |=> !armed_q;
  endproperty
  a_arm_consumed: assert property (p_arm_consumed) else $error("arm not consumed");

  // Enable and start-up delay gate every measurement
  property p_meas_enable;
    @(posedge sys_clk) disable iff (!nrst) doMeasure |-> ctrl_q.alignLogicEnable;
  endproperty
  a_meas_enable: assert property (p_meas_enable) else $error("measure while disabled");
  property p_disabled_idle;
    @(posedge sys_clk) disable iff (!nrst) (clkEn && !ctrl_q.alignLogicEnable) |=> (refCnt_q == 8'h00);
  endproperty
  a_disabled_idle: assert property (p_disabled_idle) else $error("pulse count kept while disabled");
  property p_meas_min;
    @(posedge sys_clk) disable iff (!nrst) doMeasure |-> (lmfcCnt_q >= minCount_q);
  endproperty
  a_meas_min: assert property (p_meas_min) else $error("measure before min LMFC count");

  // Read-back layout of the last error pair
  property p_err_lo_rd;
    @(posedge sys_clk) disable iff (!nrst) ($past(regRd) && $past(regAddr) == `LSC_OFF_ERR_LO && $past(clkEn))
      |-> regRdata == $past(err_q.lastPhaseError[7:0]);
  endproperty
  a_err_lo_rd: assert property (p_err_lo_rd) else $error("error low byte wrong");
  property p_err_hi_rd;
    @(posedge sys_clk) disable iff (!nrst) ($past(regRd) && $past(regAddr) == `LSC_OFF_ERR_HI && $past(clkEn))
      |-> regRdata[0] == $past(err_q.lastPhaseError[8]);
  endproperty
  a_err_hi_rd: assert property (p_err_hi_rd) else $error("error bit 8 wrong");
  property p_clrlast_level;
    @(posedge sys_clk) disable iff (!nrst) (clrLastPrev_q && ctrl_q.lastErrorClear) |-> !clrLast;
  endproperty
  a_clrlast_level: assert property (p_clrlast_level) else $error("held clear level acted again");
endmodule : lsc_sync_ctrl

// File: verif/lsc_sysref_src.sv
`timescale 1ns/10ps
module lsc_sysref_src #(
  parameter int LMFC_PERIOD = 16,
  parameter int HIGH_CYCLES = 4
) (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic nrst,
  // Pulse request from the bench
  input  wire logic fireReq,
  input  wire logic slowMode,
  // Source outputs
  output logic      sysrefPin,
  output logic      lmfcTick
);
  int lmfcCnt;
  int waitCnt;
  // Free running multiframe boundary, one tick per period
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      lmfcCnt <= 0;
    end else begin
      lmfcCnt <= (lmfcCnt == LMFC_PERIOD - 1) ? 0 : lmfcCnt + 1;
    end
  end
  assign lmfcTick = (lmfcCnt == LMFC_PERIOD - 1);
  // Slow answers idle six cycles first; the pulse is long enough for the pin synchroniser
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      waitCnt <= 0;
    end else if (fireReq) begin
      waitCnt <= slowMode ? HIGH_CYCLES + 6 : HIGH_CYCLES;
    end else if (waitCnt > 0) begin
      waitCnt <= waitCnt - 1;
    end
  end
  assign sysrefPin = (waitCnt > 0) && (waitCnt <= HIGH_CYCLES);
endmodule : lsc_sysref_src

// File: verif/testbench.sv
`timescale 1ns/10ps
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp); end end
module testbench;
  logic sys_clk = 1'b0, nrst = 1'b0, regWr = 1'b0, regRd = 1'b0, fireReq = 1'b0, slowMode = 1'b0;
  logic [9:0] regAddr = 10'h000;
  logic [7:0] regWdata = 8'h00, regRdata, rotCnt = 8'h00;
  logic [8:0] phaseErr = 9'h000;
  logic       sysrefPin, lmfcTick, rotateReq, irq;
  int         n_mismatch = 0, tests_run = 0;
  // Device under test and the reference pulse source
  lsc_sync_ctrl i_dut (.sys_clk(sys_clk), .nrst(nrst), .clkEn(1'b1), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .sysrefPin(sysrefPin), .lmfcTick(lmfcTick),
    .phaseErr(phaseErr), .rotateReq(rotateReq), .irq(irq));
  lsc_sysref_src i_src (.sys_clk(sys_clk), .nrst(nrst), .fireReq(fireReq), .slowMode(slowMode),
    .sysrefPin(sysrefPin), .lmfcTick(lmfcTick));
  initial begin
    forever #20 sys_clk = ~sys_clk;
  end
  // Rotate commands are one cycle wide, so each edge that sees one counts it
  always @(posedge sys_clk) begin
    if (rotateReq === 1'b1) rotCnt <= rotCnt + 8'h01;
  end
  task wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regWr <= 1'b1; regAddr <= a; regWdata <= d;
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe, so sample mid-cycle there
  task chk_rd(input logic [9:0] a, input logic [7:0] e, input logic [7:0] m);
    @(posedge sys_clk);
    regRd <= 1'b1; regAddr <= a;
    @(posedge sys_clk);
    regRd <= 1'b0;
    @(negedge sys_clk);
    `CHK(regRdata & m, e)
  endtask : chk_rd
  // One reference pulse, then a settle span well past the synchroniser latency
  task fire(input logic [7:0] e, input logic slow);
    logic [7:0] base;
    base = rotCnt;
    @(posedge sys_clk);
    fireReq <= 1'b1; slowMode <= slow;
    @(posedge sys_clk);
    fireReq <= 1'b0;
    repeat (24) @(posedge sys_clk);
    `CHK(rotCnt - base, e)
  endtask : fire
  task t_reset_values;
    chk_rd(10'h036, 8'h00, 8'hff);
    chk_rd(10'h038, 8'h00, 8'hff);
    chk_rd(10'h039, 8'h00, 8'hff);
    chk_rd(10'h03a, 8'h00, 8'hff);
    chk_rd(10'h3ff, 8'h00, 8'hff);
    wr(10'h036, 8'ha5);
    chk_rd(10'h036, 8'ha5, 8'hff);
    wr(10'h036, 8'h00);
  endtask : t_reset_values
  task t_one_shot;
    wr(10'h034, 8'h02);
    phaseErr <= 9'h005;
    wr(10'h03a, 8'hc1);
    fire(8'h01, 1'b1);
    fire(8'h00, 1'b0);
    chk_rd(10'h038, 8'h05, 8'hff);
    chk_rd(10'h039, 8'h40, 8'hff);
    chk_rd(10'h03c, 8'h18, 8'h18);
    wr(10'h03a, 8'h91);
    chk_rd(10'h038, 8'h00, 8'hff);
    chk_rd(10'h039, 8'h00, 8'hff);
  endtask : t_one_shot
  task t_pulse_count;
    phaseErr <= 9'h1fb;
    wr(10'h036, 8'h03);
    wr(10'h03a, 8'h82);
    fire(8'h00, 1'b0);
    fire(8'h00, 1'b1);
    fire(8'h01, 1'b0);
    chk_rd(10'h039, 8'h81, 8'hff);
    chk_rd(10'h038, 8'hfb, 8'hff);
    wr(10'h036, 8'h00);
  endtask : t_pulse_count
  task t_window_modes;
    phaseErr <= 9'h002;
    fire(8'h00, 1'b0);
    phaseErr <= 9'h003;
    fire(8'h01, 1'b0);
    wr(10'h03a, 8'h88);
    fire(8'h00, 1'b0);
    wr(10'h03a, 8'h02);
    fire(8'h00, 1'b0);
    wr(10'h03a, 8'ha2);
    chk_rd(10'h03c, 8'h00, 8'h18);
  endtask : t_window_modes
  task t_interrupt;
    wr(10'h03a, 8'h82);
    chk_rd(10'h03c, 8'h00, 8'hff);
    wr(10'h03d, 8'h01);
    repeat (2) @(posedge sys_clk);
    `CHK(irq, 1'b0)
    fire(8'h01, 1'b0);
    `CHK(irq, 1'b1)
    chk_rd(10'h03c, 8'h01, 8'h01);
    repeat (2) @(posedge sys_clk);
    `CHK(irq, 1'b0)
  endtask : t_interrupt
  task give_verdict;
    $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict
  // Whole sequence needs well under three thousand cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_mismatch++;
    give_verdict();
  end
  initial begin
    repeat (20) @(posedge sys_clk);
    nrst <= 1'b1;
    t_reset_values();
    t_one_shot();
    t_pulse_count();
    t_window_modes();
    t_interrupt();
    give_verdict();
  end
endmodule : testbench
